// >>> hw/config_bank.sv
`timescale 1ns/1ns
`include "serial_port_defs.svh"

module config_bank import serial_port_pkg::*; #(
    parameter logic [7:0] VARIANT_ID = 8'h5A // Arbitrary value.
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Write and read ports
    input wire logic wr_en_i,
    input wire logic [12:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [12:0] rd_addr_i,
    output logic [7:0] rd_data_o,
    // Settings
    output logic lsb_first_o,
    output logic separate_output_select_o,
    output logic soft_reset_o,
    output logic [7:0] active_pwr_sync_o
);

    bank_state_s s_ff;
    bank_state_s nxt_s;

    // ======================================================================
    // Next state
    always_comb begin
        nxt_s = s_ff;
        nxt_s.update = 1'b0;
        if (s_ff.update) begin
            nxt_s.act_ps = s_ff.buf_ps;
        end
        if (wr_en_i) begin
            unique case (wr_addr_i)
                `ADDR_SETUP: nxt_s.setup = wr_data_i;
                `ADDR_RB_SEL: nxt_s.rb_sel = {7'h00, wr_data_i[`RB_SEL_ACTIVE]};
                `ADDR_PWR_SYNC: nxt_s.buf_ps = wr_data_i;
                `ADDR_COMMIT: nxt_s.update = wr_data_i[`COMMIT_BIT];
                default: nxt_s.update = 1'b0; // Identifier, reserved and blank space drop writes.
            endcase
        end
        // The setup register is spared so that software can end the reset.
        if (s_ff.setup[`SETUP_SOFT_RST]) begin
            nxt_s.rb_sel = `RB_SEL_RST;
            nxt_s.buf_ps = `PWR_SYNC_RST;
            nxt_s.act_ps = `PWR_SYNC_RST;
            nxt_s.update = 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s_ff <= '{setup: `SETUP_RST, rb_sel: `RB_SEL_RST, buf_ps: `PWR_SYNC_RST,
                      act_ps: `PWR_SYNC_RST, update: 1'b0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ======================================================================
    // Readback
    always_comb begin
        unique case (rd_addr_i)
            `ADDR_SETUP: rd_data_o = s_ff.setup;
            `ADDR_VARIANT: rd_data_o = VARIANT_ID;
            `ADDR_RB_SEL: rd_data_o = s_ff.rb_sel;
            `ADDR_PWR_SYNC: rd_data_o = s_ff.rb_sel[`RB_SEL_ACTIVE] ?
                s_ff.act_ps : s_ff.buf_ps;
            `ADDR_COMMIT: rd_data_o = {7'h00, s_ff.update};
            default: rd_data_o = 8'h00;
        endcase
    end

    // The instruction length bit is stored but never shortens a frame.
    assign lsb_first_o = s_ff.setup[`SETUP_LSB_FIRST];
    assign separate_output_select_o = s_ff.setup[`SETUP_SEP_OUT];
    assign soft_reset_o = s_ff.setup[`SETUP_SOFT_RST];
    assign active_pwr_sync_o = s_ff.act_ps;

    // ======================================================================
    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    a_commit_self_clear: assert property (s_ff.update |=> !s_ff.update)
        else $error("commit bit did not clear itself");
    a_commit_copies: assert property (s_ff.update |=> s_ff.act_ps == $past(s_ff.buf_ps))
        else $error("commit did not copy buffer to active");
    a_variant_fixed: assert property ((rd_addr_i == `ADDR_VARIANT) |-> rd_data_o == VARIANT_ID)
        else $error("variant identifier read wrong");
    a_read_active: assert property ((rd_addr_i == `ADDR_PWR_SYNC && s_ff.rb_sel[0])
        |-> rd_data_o == s_ff.act_ps)
        else $error("active bank not returned");
    a_read_buffer: assert property ((rd_addr_i == `ADDR_PWR_SYNC && !s_ff.rb_sel[0])
        |-> rd_data_o == s_ff.buf_ps)
        else $error("buffer bank not returned");
    a_soft_reset_hold: assert property (s_ff.setup[`SETUP_SOFT_RST] |=>
        s_ff.buf_ps == `PWR_SYNC_RST && s_ff.rb_sel == `RB_SEL_RST)
        else $error("soft reset did not restore defaults");

    c_commit: cover property (s_ff.update ##1 s_ff.act_ps != `PWR_SYNC_RST);
    c_soft_reset: cover property (s_ff.setup[`SETUP_SOFT_RST] ##[1:1000]
        !s_ff.setup[`SETUP_SOFT_RST]);

endmodule

// >>> hw/serial_port_config.sv
`timescale 1ns/1ns
`include "serial_port_defs.svh"

module serial_port_config import serial_port_pkg::*; #(
    parameter logic [7:0] VARIANT_ID = 8'h5A // Arbitrary value.
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Serial pins
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic sdio_i,
    output logic sdio_o,
    output logic sdio_oe_o,
    output logic serial_data_out_pin_o,
    output logic serial_data_out_pin_oe_o,
    // Device controls
    output logic [7:0] active_pwr_sync_o,
    output logic soft_reset_o
);

    port_state_s s_ff;
    port_state_s nxt_s;
    logic lsb_first;
    logic sep_out;
    logic wr_en;
    logic [12:0] wr_addr;
    logic [7:0] wr_data;
    logic [12:0] rd_addr;
    logic [7:0] rd_data;
    logic sclk_rise;
    logic sclk_fall;
    logic [15:0] sh_next;
    logic [7:0] byte_in;
    logic [12:0] addr_step;
    logic reading;

    config_bank #(
        .VARIANT_ID(VARIANT_ID)
    ) u_bank (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .wr_en_i(wr_en),
        .wr_addr_i(wr_addr),
        .wr_data_i(wr_data),
        .rd_addr_i(rd_addr),
        .rd_data_o(rd_data),
        .lsb_first_o(lsb_first),
        .separate_output_select_o(sep_out),
        .soft_reset_o(soft_reset_o),
        .active_pwr_sync_o(active_pwr_sync_o)
    );

    // The host must hold each serial clock level for at least one clock, or an edge is lost.
    assign sclk_rise = sclk_i & ~s_ff.sclk_prev;
    assign sclk_fall = ~sclk_i & s_ff.sclk_prev;

    // ======================================================================
    // Frame engine
    // Bits are sampled on the rising serial clock edge and read data changes on the
    // falling edge, so the host always sees a full half period of setup.
    always_comb begin
        nxt_s = s_ff;
        nxt_s.sclk_prev = sclk_i;
        wr_en = 1'b0;
        wr_addr = s_ff.addr;
        wr_data = 8'h00;
        rd_addr = s_ff.addr;
        sh_next = lsb_first ? {sdio_i, s_ff.shift[15:1]} : {s_ff.shift[14:0], sdio_i};
        byte_in = lsb_first ? sh_next[15:8] : sh_next[7:0];
        addr_step = lsb_first ? s_ff.addr + 13'h0001 : s_ff.addr - 13'h0001;
        if (cs_n_i) begin
            nxt_s.phase = PH_IDLE;
            nxt_s.bit_cnt = 4'h0;
            nxt_s.out_bit = 1'b0;
        end else begin
            unique case (s_ff.phase)
                PH_IDLE, PH_INSTR: begin
                    nxt_s.phase = PH_INSTR;
                    if (sclk_rise) begin
                        nxt_s.shift = sh_next;
                        nxt_s.bit_cnt = s_ff.bit_cnt + 4'h1;
                        // Every frame opens with a 16-bit instruction.
                        if (s_ff.bit_cnt == `INSTR_LAST) begin
                            nxt_s.phase = PH_DATA;
                            nxt_s.rd = sh_next[15];
                            nxt_s.len = sh_next[14:13];
                            nxt_s.addr = sh_next[12:0];
                            nxt_s.bit_cnt = 4'h0;
                            nxt_s.byte_cnt = 2'h0;
                            rd_addr = sh_next[12:0];
                            nxt_s.tx = rd_data;
                        end
                    end
                end
                PH_DATA: begin
                    if (sclk_rise) begin
                        nxt_s.shift = sh_next;
                        nxt_s.bit_cnt = s_ff.bit_cnt + 4'h1;
                        if (s_ff.bit_cnt == `BYTE_LAST) begin
                            wr_en = ~s_ff.rd;
                            wr_data = byte_in;
                            nxt_s.addr = addr_step;
                            nxt_s.bit_cnt = 4'h0;
                            nxt_s.byte_cnt = s_ff.byte_cnt + 2'h1;
                            rd_addr = addr_step;
                            nxt_s.tx = rd_data;
                            if (s_ff.len != `LEN_STREAM && s_ff.byte_cnt == s_ff.len) begin
                                nxt_s.phase = PH_DONE;
                            end
                        end
                    end else if (sclk_fall && s_ff.rd) begin
                        nxt_s.out_bit = lsb_first ? s_ff.tx[0] : s_ff.tx[7];
                        nxt_s.tx = lsb_first ? {1'b0, s_ff.tx[7:1]} : {s_ff.tx[6:0], 1'b0};
                    end
                end
                PH_DONE: nxt_s.phase = PH_DONE;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s_ff <= '{phase: PH_IDLE, sclk_prev: 1'b0, shift: 16'h0000, bit_cnt: 4'h0,
                      rd: 1'b0, len: 2'h0, byte_cnt: 2'h0, addr: 13'h0000, tx: 8'h00,
                      out_bit: 1'b0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ======================================================================
    // Pin drivers
    assign reading = ~cs_n_i & s_ff.rd & (s_ff.phase == PH_DATA || s_ff.phase == PH_DONE);
    assign sdio_o = s_ff.out_bit;
    assign serial_data_out_pin_o = s_ff.out_bit;
    assign sdio_oe_o = reading & ~sep_out;
    assign serial_data_out_pin_oe_o = reading & sep_out;

    // ======================================================================
    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // Address stepping follows the bit order in force when a byte completes.
    a_addr_steps_down: assert property ((s_ff.phase == PH_DATA && sclk_rise && !cs_n_i
        && s_ff.bit_cnt == `BYTE_LAST && !lsb_first)
        |=> s_ff.addr == $past(s_ff.addr) - 13'h0001)
        else $error("address did not step down");
    a_addr_steps_up: assert property ((s_ff.phase == PH_DATA && sclk_rise && !cs_n_i
        && s_ff.bit_cnt == `BYTE_LAST && lsb_first)
        |=> s_ff.addr == $past(s_ff.addr) + 13'h0001)
        else $error("address did not step up");
    a_bidir_mode: assert property (!sep_out |-> !serial_data_out_pin_oe_o)
        else $error("output pin driven in bidirectional mode");
    a_separate_mode: assert property ((sep_out && reading)
        |-> serial_data_out_pin_oe_o && !sdio_oe_o)
        else $error("read data not on output pin");
    a_idle_quiet: assert property (cs_n_i |-> !sdio_oe_o && !serial_data_out_pin_oe_o)
        else $error("data pin driven outside a frame");
    a_bidir_drives: assert property ((!sep_out && reading) |-> sdio_oe_o)
        else $error("read data not on data pin");
    a_pins_exclusive: assert property (!(sdio_oe_o && serial_data_out_pin_oe_o))
        else $error("both data outputs driven");
    // In bidirectional mode the data pin turns around right after the last instruction rise, so the host must let go.
    a_read_turns_on: assert property ((s_ff.phase == PH_INSTR && sclk_rise && !cs_n_i
        && s_ff.bit_cnt == `INSTR_LAST && sh_next[15])
        |=> cs_n_i || sdio_oe_o || serial_data_out_pin_oe_o)
        else $error("read frame did not drive read data");

    // ======================================================================
    // Bit order checks
    a_msb_shift_in: assert property ((s_ff.phase != PH_DONE && sclk_rise && !cs_n_i
        && !lsb_first) |=> s_ff.shift == {$past(s_ff.shift[14:0]), $past(sdio_i)})
        else $error("MSB first bit not shifted in at the bottom");
    a_lsb_shift_in: assert property ((s_ff.phase != PH_DONE && sclk_rise && !cs_n_i
        && lsb_first) |=> s_ff.shift == {$past(sdio_i), $past(s_ff.shift[15:1])})
        else $error("LSB first bit not shifted in at the top");
    a_msb_bit_out: assert property ((s_ff.phase == PH_DATA && sclk_fall && !cs_n_i
        && s_ff.rd && !lsb_first) |=> s_ff.out_bit == $past(s_ff.tx[7]))
        else $error("MSB first read bit wrong");
    a_lsb_bit_out: assert property ((s_ff.phase == PH_DATA && sclk_fall && !cs_n_i
        && s_ff.rd && lsb_first) |=> s_ff.out_bit == $past(s_ff.tx[0]))
        else $error("LSB first read bit wrong");
    a_msb_write_byte: assert property ((wr_en && !lsb_first)
        |-> wr_data == {s_ff.shift[6:0], sdio_i})
        else $error("MSB first write byte misassembled");
    a_lsb_write_byte: assert property ((wr_en && lsb_first)
        |-> wr_data == {sdio_i, s_ff.shift[15:9]})
        else $error("LSB first write byte misassembled");

    // ======================================================================
    // Framing checks
    a_long_instr: assert property ((s_ff.phase == PH_INSTR && sclk_rise && !cs_n_i
        && s_ff.bit_cnt == `INSTR_LAST) |=> s_ff.phase == PH_DATA)
        else $error("instruction did not end after 16 bits");
    a_write_lands: assert property (wr_en |-> s_ff.phase == PH_DATA && !s_ff.rd)
        else $error("write outside a write frame");
    a_bit_cnt_range: assert property (s_ff.phase == PH_DATA |-> s_ff.bit_cnt <= `BYTE_LAST)
        else $error("data bit counter ran past a byte");
    a_byte_counted: assert property ((s_ff.phase == PH_DATA && sclk_rise && !cs_n_i
        && s_ff.bit_cnt == `BYTE_LAST) |=> s_ff.byte_cnt == $past(s_ff.byte_cnt) + 2'h1)
        else $error("byte counter did not advance");
    a_single_byte_end: assert property ((s_ff.phase == PH_DATA && sclk_rise && !cs_n_i
        && s_ff.bit_cnt == `BYTE_LAST && s_ff.len == 2'h0) |=> s_ff.phase == PH_DONE)
        else $error("single byte frame did not end");
    a_done_no_write: assert property (s_ff.phase == PH_DONE |-> !wr_en)
        else $error("write beyond the frame length");
    // A partial byte is simply dropped when chip select rises early.
    a_abort_idle: assert property (cs_n_i |=> s_ff.phase == PH_IDLE && s_ff.bit_cnt == 4'h0
        && !s_ff.out_bit)
        else $error("raised chip select did not end the frame");

    // ======================================================================
    // Coverage
    c_write_frame: cover property (wr_en);
    c_read_separate: cover property (serial_data_out_pin_oe_o);
    c_read_bidir: cover property (sdio_oe_o);
    c_read_lsb: cover property (reading && lsb_first);

endmodule

// >>> hw/serial_port_defs.svh
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

// ==========================================================================
// Register offsets
`define ADDR_SETUP 13'h0000
`define ADDR_VARIANT 13'h0003
`define ADDR_RB_SEL 13'h0004
`define ADDR_PWR_SYNC 13'h0230
`define ADDR_RSVD_231 13'h0231
`define ADDR_COMMIT 13'h0232

// ==========================================================================
// Field positions
`define SETUP_SEP_OUT 0
`define SETUP_LSB_FIRST 1
`define SETUP_SOFT_RST 2
`define SETUP_LONG_INSTR 3
`define RB_SEL_ACTIVE 0
`define COMMIT_BIT 0

// ==========================================================================
// Reset values
`define SETUP_RST 8'h18
`define RB_SEL_RST 8'h00
`define PWR_SYNC_RST 8'h00
`define COMMIT_RST 8'h00

// ==========================================================================
// Serial framing counts
`define INSTR_LAST 4'hF
`define BYTE_LAST 4'h7
`define LEN_STREAM 2'h3

`endif

// >>> hw/serial_port_pkg.sv
package serial_port_pkg;

    typedef enum logic [1:0] {
        PH_IDLE  = 2'b00,
        PH_INSTR = 2'b01,
        PH_DATA  = 2'b10,
        PH_DONE  = 2'b11
    } phase_e;

    typedef struct packed {
        phase_e phase;
        logic sclk_prev;
        logic [15:0] shift;
        logic [3:0] bit_cnt;
        logic rd;
        logic [1:0] len;
        logic [1:0] byte_cnt;
        logic [12:0] addr;
        logic [7:0] tx;
        logic out_bit;
    } port_state_s;

    typedef struct packed {
        logic [7:0] setup;
        logic [7:0] rb_sel;
        logic [7:0] buf_ps;
        logic [7:0] act_ps;
        logic update;
    } bank_state_s;

endpackage

// >>> sim/serial_host.sv
`timescale 1ns/1ns

module serial_host (
    // Clock
    input wire logic clock_i,
    // Pin levels seen by the host
    input wire logic sdio_i,
    input wire logic out_pin_i,
    // Host-driven pins
    output logic cs_n_o,
    output logic sclk_o,
    output logic sdio_o,
    output logic sdio_oe_o,
    // Captured read bytes
    output logic rd_valid_o,
    output logic [7:0] rd_byte_o
);
    // ==========================================================================
    // Idle levels
    // The serial clock stands low between frames.
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sdio_o = 1'b0;
        sdio_oe_o = 1'b0;
        rd_valid_o = 1'b0;
        rd_byte_o = 8'h00;
    end

    // ==========================================================================
    // Bit and frame tasks, entered at a falling clock edge
    // A released data line flips so a stale level never passes for read data.
    task automatic put_bit(input logic b, input logic drive, input logic rel, input logic sep,
                           output logic got);
        sclk_o = 1'b0;
        sdio_oe_o = drive;
        sdio_o = drive ? b : ~sdio_o;
        repeat (4) @(negedge clock_i);
        got = sep ? out_pin_i : sdio_i;
        sclk_o = 1'b1;
        // The device drives right after the last instruction rise of a read, so let go here.
        if (rel) sdio_oe_o = 1'b0;
        repeat (4) @(negedge clock_i);
    endtask

    task automatic frame(input logic rd, input logic [1:0] len, input logic [12:0] addr,
                         input logic lsb, input logic sep, input logic [31:0] wdata);
        logic [15:0] ins;
        logic [7:0] b;
        logic g;
        ins = {rd, len, addr};
        @(negedge clock_i);
        cs_n_o = 1'b0;
        @(negedge clock_i);
        for (int i = 0; i < 16; i++) begin
            put_bit(lsb ? ins[i] : ins[15-i], 1'b1, rd && i == 15, sep, g);
        end
        for (int k = 0; k <= int'(len); k++) begin
            for (int i = 0; i < 8; i++) begin
                put_bit(lsb ? wdata[8*k+i] : wdata[8*k+7-i], !rd, 1'b0, sep, g);
                b[lsb ? i : 7-i] = g;
            end
            if (rd) begin
                rd_byte_o = b;
                rd_valid_o = 1'b1;
                @(negedge clock_i);
                rd_valid_o = 1'b0;
            end
        end
        sclk_o = 1'b0;
        sdio_oe_o = 1'b0;
        sdio_o = ~sdio_o;
        repeat (4) @(negedge clock_i);
        cs_n_o = 1'b1;
        repeat (4) @(negedge clock_i);
    endtask
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ns
`include "serial_port_defs.svh"

module tb_top;
    // ==========================================================================
    // Clock, reset and wiring
    localparam logic [7:0] VID = 8'h3C; // Arbitrary value.
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic cs_n, sclk, h_sdio, h_oe, rd_valid, d_sdio, d_oe, d_out, d_out_oe, soft_rst;
    logic sdio_w, out_w;
    logic [7:0] rd_byte, act_ps, v;
    logic lsb = 1'b0;
    logic sep = 1'b0;
    logic [7:0] exp_q[$];
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #2 clock_i = ~clock_i;
    assign sdio_w = d_oe ? d_sdio : h_sdio;
    assign out_w = d_out_oe ? d_out : h_sdio;

    serial_port_config #(.VARIANT_ID(VID)) dut_u (
        .clock_i(clock_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk), .sdio_i(sdio_w),
        .sdio_o(d_sdio), .sdio_oe_o(d_oe), .serial_data_out_pin_o(d_out),
        .serial_data_out_pin_oe_o(d_out_oe), .active_pwr_sync_o(act_ps),
        .soft_reset_o(soft_rst));
    serial_host host_u (
        .clock_i(clock_i), .sdio_i(sdio_w), .out_pin_i(out_w), .cs_n_o(cs_n), .sclk_o(sclk),
        .sdio_o(h_sdio), .sdio_oe_o(h_oe), .rd_valid_o(rd_valid), .rd_byte_o(rd_byte));

    // ==========================================================================
    // Checking
    task automatic chk_port(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_read(input logic [7:0] got);
        logic [7:0] e;
        e = (exp_q.size() > 0) ? exp_q.pop_front() : ~got;
        chk_port(got, e);
    endtask

    task automatic final_report();
        if (exp_q.size() != 0) n_errors++;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clock_i) begin
        cycles++;
        if (rd_valid === 1'b1) chk_read(rd_byte);
        if ((d_oe === 1'b1 && (sep || h_oe)) || (d_out_oe === 1'b1 && !sep)) begin
            n_errors++;
            $display("CHECK FAILED at %0t: pin driven in the wrong mode", $time);
        end
        if (cycles > 40000) begin
            n_errors++;
            final_report();
        end
    end

    // ==========================================================================
    // Register access tasks
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        host_u.frame(1'b0, 2'd0, a, lsb, sep, {24'h0000_00, d});
    endtask

    task automatic rd(input logic [12:0] a, input logic [1:0] len, input logic [15:0] e);
        exp_q.push_back(e[7:0]);
        if (len != 2'd0) exp_q.push_back(e[15:8]);
        host_u.frame(1'b1, len, a, lsb, sep, 32'h0000_0000);
    endtask

    // ==========================================================================
    // Main sequence
    initial begin
        void'($urandom(32'hc869_5e1f));
        repeat (20) @(posedge clock_i);
        @(negedge clock_i);
        rst_i = 1'b0;
        rd(`ADDR_SETUP, 2'd0, 16'h0018);
        rd(`ADDR_VARIANT, 2'd0, {8'h00, VID});
        rd(`ADDR_RB_SEL, 2'd0, 16'h0000);
        rd(`ADDR_COMMIT, 2'd0, 16'h0000);
        wr(`ADDR_VARIANT, ~VID);
        wr(`ADDR_RSVD_231, 8'hFF);
        rd(`ADDR_RB_SEL, 2'd1, {VID, 8'h00});
        rd(`ADDR_RSVD_231, 2'd0, 16'h0000);
        // Buffered register and commit.
        v = 8'($urandom()) | 8'h01;
        wr(`ADDR_PWR_SYNC, v);
        chk_port(act_ps, 8'h00);
        rd(`ADDR_PWR_SYNC, 2'd0, {8'h00, v});
        wr(`ADDR_RB_SEL, 8'h01);
        rd(`ADDR_PWR_SYNC, 2'd0, 16'h0000);
        wr(`ADDR_COMMIT, 8'h01);
        chk_port(act_ps, v);
        rd(`ADDR_COMMIT, 2'd0, 16'h0000);
        rd(`ADDR_PWR_SYNC, 2'd0, {8'h00, v});
        // Least significant bit first, upward stepping.
        wr(`ADDR_SETUP, 8'h5A);
        lsb = 1'b1;
        rd(`ADDR_VARIANT, 2'd1, {8'h01, VID});
        // Streaming read runs upward into unmapped space until chip select rises.
        exp_q.push_back(VID);
        exp_q.push_back(8'h01);
        exp_q.push_back(8'h00);
        exp_q.push_back(8'h00);
        host_u.frame(1'b1, `LEN_STREAM, `ADDR_VARIANT, lsb, sep, 32'h0000_0000);
        // Separate output pin.
        wr(`ADDR_SETUP, 8'hDB);
        sep = 1'b1;
        rd(`ADDR_SETUP, 2'd0, 16'h00DB);
        v = 8'($urandom()) | 8'h80;
        wr(`ADDR_PWR_SYNC, v);
        // Soft reset holds defaults until cleared.
        wr(`ADDR_SETUP, 8'hFF);
        chk_port({7'h00, soft_rst}, 8'h01);
        chk_port(act_ps, 8'h00);
        rd(`ADDR_RB_SEL, 2'd0, 16'h0000);
        rd(`ADDR_PWR_SYNC, 2'd0, 16'h0000);
        wr(`ADDR_SETUP, 8'hDB);
        chk_port({7'h00, soft_rst}, 8'h00);
        wr(`ADDR_PWR_SYNC, v);
        rd(`ADDR_PWR_SYNC, 2'd0, {8'h00, v});
        final_report();
    end
endmodule
